// ### hdl/cds_pkg.sv
// Purpose: Shared constants and types for the current DAC update scheduler
// Assumes: Control register byte layout as the processor sees it
// Notes:   Reset of the control byte is 8'h72
package cds_pkg;

	// ------------------------------------------------------------------
	// Control register layout
	// ------------------------------------------------------------------
	localparam int        CDS_EN_BIT      = 7;
	localparam int        CDS_TRIG_HI     = 6;
	localparam int        CDS_TRIG_LO     = 4;
	localparam int        CDS_FS_HI       = 1;
	localparam int        CDS_FS_LO       = 0;
	localparam logic[7:0] CDS_CTRL_RST    = 8'h72;
	localparam logic[7:0] CDS_CTRL_WMASK  = 8'hf3;
	localparam logic[7:0] CDS_DATA_RST    = 8'h00;
	localparam int        CDS_DAC_W       = 10;

	// ------------------------------------------------------------------
	// Trigger codes and full-scale codes
	// ------------------------------------------------------------------
	localparam logic[2:0] CDS_TRIG_TMR0   = 3'h0;
	localparam logic[2:0] CDS_TRIG_TMR3   = 3'h3;
	localparam logic[2:0] CDS_TRIG_RISE   = 3'h4;
	localparam logic[2:0] CDS_TRIG_FALL   = 3'h5;
	localparam logic[2:0] CDS_TRIG_BOTH   = 3'h6;
	localparam logic[2:0] CDS_TRIG_DEMAND = 3'h7;
	localparam logic[1:0] CDS_FS_0P5MA    = 2'h0;
	localparam logic[1:0] CDS_FS_1MA      = 2'h1;
	localparam logic[1:0] CDS_FS_2MA      = 2'h2;

	// ------------------------------------------------------------------
	// Register write carrier
	// ------------------------------------------------------------------
	typedef struct packed {
		logic       ctrl_we;
		logic       high_we;
		logic       low_we;
		logic [7:0] wdata;
	} cds_wr_t;

	// Analog side controls
	typedef struct packed {
		logic       bias_on;
		logic       pin_analog;
		logic [1:0] full_scale;
		logic [9:0] code;
	} cds_ana_t;

endpackage

// ### hdl/cds_edge.sv
// Purpose: Synchronise the convert start pin and detect selected edges
// Assumes: One clock; pin asynchronous to it
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module cds_edge
	import cds_pkg::*;
(
	input  wire logic       core_clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic       pin_i,
	input  wire logic [2:0] sel_i,
	output logic            strobe_o
);

	logic [2:0] sync_reg;
	logic [2:0] sync_next;
	logic [1:0] fill_reg;
	logic [1:0] fill_next;
	logic       rise;
	logic       fall;

	always_comb begin
		sync_next = {sync_reg[1:0], pin_i};
		fill_next = fill_reg;
		if (!(&fill_reg)) begin
			fill_next = fill_reg + 2'h1;
		end
		// No edges until all stages hold real pin samples
		rise      = &fill_reg & sync_reg[1] & ~sync_reg[2];
		fall      = &fill_reg & ~sync_reg[1] & sync_reg[2];
		case (sel_i)
			CDS_TRIG_RISE: strobe_o = rise; // RQ12
			CDS_TRIG_FALL: strobe_o = fall; // RQ12
			CDS_TRIG_BOTH: strobe_o = rise | fall; // RQ11
			default:       strobe_o = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sync_reg <= 3'h0;
			fill_reg <= 2'h0;
		end else begin
			sync_reg <= sync_next;
			fill_reg <= fill_next;
		end
	end

	edge_pulse_a: assert property (@(posedge core_clk_i) // RQ12
		disable iff (sys_rst_i)
		strobe_o |-> (&fill_reg && sync_reg[1] != sync_reg[2]))
		else $error("edge strobe without a pin change");

endmodule

// ### hdl/cds_top.sv
// Purpose: Control, staging and update scheduling for a 10-bit current DAC
// Assumes: Register writes arrive as one-cycle strobes with byte data
// Notes:   Output latch changes only on the selected update event
`timescale 1ns/1ps
// How it works
// RQ1: Enable hands port pin to converter output
// RQ2: Bias reference on exactly while enabled
// RQ3: Three full-scale settings: 0.5, 1, 2 mA
// RQ4: Software sets port skip bit for pin
// RQ5: Trigger field bits 6:4, default on-demand
// RQ6: On-demand: low byte held until high write
// RQ7: Software writes low byte then high byte
// RQ8: Eight-bit use writes only high byte
// RQ9: Codes 0-3 update on timer 0-3 overflow
// RQ10: Codes 4-6 update on start pin edge
// RQ11: Edge codes choose rising, falling or both
// RQ12: 4 rising, 5 falling, 6 both; synchronised
// RQ13: Data word left-justified across two bytes
// RQ14: Full-scale field bits 1:0, default 2 mA
module cds_top
	import cds_pkg::*;
(
	input  wire logic       core_clk_i,
	input  wire logic       sys_rst_i,
	input  wire cds_wr_t    wr_i,
	input  wire logic [3:0] timer_ovf_i,
	input  wire logic       convert_start_pin_i,
	input  wire logic       gpio_out_i,
	input  wire logic       gpio_oe_i,
	input  wire logic       gpio_pullup_i,
	output logic [7:0]      dac_control_reg_o,
	output logic [7:0]      dac_data_high_o,
	output logic [7:0]      dac_data_low_o,
	output cds_ana_t        ana_o,
	output logic            pin_out_o,
	output logic            pin_oe_o,
	output logic            pin_pullup_o,
	output logic            update_o
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	logic [7:0]  ctrl_reg;
	logic [7:0]  ctrl_next;
	logic [7:0]  high_reg;
	logic [7:0]  high_next;
	logic [7:0]  low_reg;
	logic [7:0]  low_next;
	logic [9:0]  latch_reg;
	logic [9:0]  latch_next;
	logic        upd_reg;
	logic        upd_next;
	logic [2:0]  trig;
	logic        enable;
	logic        edge_strobe;
	logic        fire;
	logic [7:0]  cur_high;
	logic [7:0]  cur_low;

	assign trig   = ctrl_reg[CDS_TRIG_HI:CDS_TRIG_LO]; // RQ5
	assign enable = ctrl_reg[CDS_EN_BIT];

	// Trigger codes that wait for a start pin edge
	function automatic logic edge_mode(input logic [2:0] code);
		return code >= CDS_TRIG_RISE && code <= CDS_TRIG_BOTH;
	endfunction

	// ------------------------------------------------------------------
	// Start pin edge detection
	// ------------------------------------------------------------------
	cds_edge u_edge (
		.core_clk_i (core_clk_i),
		.sys_rst_i  (sys_rst_i),
		.pin_i      (convert_start_pin_i),
		.sel_i      (trig),
		.strobe_o   (edge_strobe)
	);

	// ------------------------------------------------------------------
	// Update event selection and next values
	// ------------------------------------------------------------------
	always_comb begin
		ctrl_next = ctrl_reg;
		high_next = high_reg;
		low_next  = low_reg;
		fire      = 1'b0;
		if (wr_i.ctrl_we) begin
			ctrl_next = wr_i.wdata & CDS_CTRL_WMASK;
		end
		if (wr_i.high_we) begin
			high_next = wr_i.wdata;
		end
		if (wr_i.low_we) begin
			low_next = wr_i.wdata; // RQ6
		end
		// Update event for the selected trigger
		case (trig)
			CDS_TRIG_DEMAND: fire = wr_i.high_we; // RQ6
			CDS_TRIG_RISE,
			CDS_TRIG_FALL,
			CDS_TRIG_BOTH:   fire = edge_strobe; // RQ10
			default:         fire = timer_ovf_i[trig[1:0]]; // RQ9
		endcase
		// Same-cycle write is included in the copy
		cur_high   = high_next;
		cur_low    = low_next;
		latch_next = latch_reg;
		if (fire) begin
			latch_next = {cur_high, cur_low[7:6]}; // RQ13
		end
		upd_next = fire;
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ctrl_reg  <= CDS_CTRL_RST; // RQ5 RQ14
			high_reg  <= CDS_DATA_RST;
			low_reg   <= CDS_DATA_RST;
			latch_reg <= 10'h000;
			upd_reg   <= 1'b0;
		end else begin
			ctrl_reg  <= ctrl_next;
			high_reg  <= high_next;
			low_reg   <= low_next;
			latch_reg <= latch_next;
			upd_reg   <= upd_next;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	always_comb begin
		dac_control_reg_o   = ctrl_reg;
		dac_data_high_o     = high_reg;
		dac_data_low_o      = {low_reg[7:6], 6'h00};
		update_o            = upd_reg;
		ana_o.bias_on       = enable; // RQ2
		ana_o.pin_analog    = enable; // RQ1
		ana_o.full_scale    = ctrl_reg[CDS_FS_HI:CDS_FS_LO]; // RQ3 RQ14
		ana_o.code          = latch_reg;
		pin_out_o           = enable ? 1'b0 : gpio_out_i; // RQ1
		pin_oe_o            = enable ? 1'b0 : gpio_oe_i; // RQ1
		pin_pullup_o        = enable ? 1'b0 : gpio_pullup_i; // RQ1
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	// Pin, bias, full scale and control readback
	pin_release_a: assert property (@(posedge core_clk_i) // RQ1
		disable iff (sys_rst_i)
		enable |-> (!pin_oe_o && !pin_pullup_o && ana_o.pin_analog))
		else $error("pin driven while converter enabled");
	pin_gpio_a: assert property (@(posedge core_clk_i) // RQ1
		disable iff (sys_rst_i)
		!enable |-> (pin_out_o == gpio_out_i && pin_oe_o == gpio_oe_i
			&& pin_pullup_o == gpio_pullup_i && !ana_o.pin_analog))
		else $error("port pin not plain while converter disabled");
	bias_follows_a: assert property (@(posedge core_clk_i) // RQ2
		disable iff (sys_rst_i)
		ana_o.bias_on == ctrl_reg[CDS_EN_BIT])
		else $error("bias not tracking enable");
	fs_field_a: assert property (@(posedge core_clk_i) // RQ3 RQ14
		disable iff (sys_rst_i)
		wr_i.ctrl_we |=> ana_o.full_scale == $past(wr_i.wdata[1:0]))
		else $error("full-scale field not taken from bits 1:0");
	ctrl_read_a: assert property (@(posedge core_clk_i) // RQ5
		disable iff (sys_rst_i)
		wr_i.ctrl_we
		|=> dac_control_reg_o == ($past(wr_i.wdata) & CDS_CTRL_WMASK))
		else $error("control readback wrong");
	// Update events
	demand_latch_a: assert property (@(posedge core_clk_i) // RQ5
		disable iff (sys_rst_i)
		(trig == CDS_TRIG_DEMAND && !wr_i.ctrl_we && wr_i.high_we)
		|=> ana_o.code[9:2] == $past(wr_i.wdata))
		else $error("high write did not latch in demand mode");
	demand_pulse_a: assert property (@(posedge core_clk_i) // RQ6
		disable iff (sys_rst_i)
		(trig == CDS_TRIG_DEMAND && wr_i.high_we) |=> update_o)
		else $error("no update pulse after high write");
	low_held_a: assert property (@(posedge core_clk_i) // RQ6
		disable iff (sys_rst_i)
		(trig == CDS_TRIG_DEMAND && !wr_i.high_we)
		|=> $stable(ana_o.code))
		else $error("output moved without high write");
	timer_fire_a: assert property (@(posedge core_clk_i) // RQ9
		disable iff (sys_rst_i)
		(trig <= CDS_TRIG_TMR3 && timer_ovf_i[trig[1:0]])
		|=> update_o ##0 ana_o.code == {high_reg, low_reg[7:6]})
		else $error("timer overflow missed");
	timer_hold_a: assert property (@(posedge core_clk_i) // RQ9
		disable iff (sys_rst_i)
		(trig <= CDS_TRIG_TMR3 && !timer_ovf_i[trig[1:0]])
		|=> !update_o)
		else $error("update without selected overflow");
	edge_fire_a: assert property (@(posedge core_clk_i) // RQ10
		disable iff (sys_rst_i)
		(edge_mode(trig) && edge_strobe)
		|=> update_o ##0 ana_o.code == {high_reg, low_reg[7:6]})
		else $error("pin edge did not latch data");
	edge_hold_a: assert property (@(posedge core_clk_i) // RQ10
		disable iff (sys_rst_i)
		(edge_mode(trig) && !edge_strobe)
		|=> $stable(ana_o.code))
		else $error("output moved without pin edge");
	// Data layout
	high_read_a: assert property (@(posedge core_clk_i) // RQ6
		disable iff (sys_rst_i)
		wr_i.high_we |=> dac_data_high_o == $past(wr_i.wdata))
		else $error("high byte readback wrong");
	low_read_a: assert property (@(posedge core_clk_i) // RQ13
		disable iff (sys_rst_i)
		wr_i.low_we |=> dac_data_low_o == {$past(wr_i.wdata[7:6]), 6'h00})
		else $error("low byte readback wrong");
	left_just_a: assert property (@(posedge core_clk_i) // RQ13
		disable iff (sys_rst_i)
		update_o |-> ana_o.code[1:0] == low_reg[7:6])
		else $error("low bits not from low byte 7:6");

endmodule

// ### bench/cds_ana_model.sv
// Purpose: Far-side model of the current converter and its port pin
// Assumes: Weak pull-up on the pin; analog route reads low
// Notes:   Full scale reported in microamps
`timescale 1ns/1ps
module cds_ana_model
	import cds_pkg::*;
(
	input  wire cds_ana_t ana_i,
	input  wire logic     pin_out_i,
	input  wire logic     pin_oe_i,
	input  wire logic     pin_pullup_i,
	input  wire logic     skip_i,
	output logic          pin_o,
	output int            fs_ua_o
);
	// Pin level from whichever party drives it
	// Unskipped analog pin clashes with a crossbar peripheral
	assign pin_o = (ana_i.pin_analog & ~skip_i) ? 1'bx :
		(pin_oe_i ? pin_out_i : pin_pullup_i & ~ana_i.pin_analog);
	assign fs_ua_o = ana_i.full_scale[1] ? 2000 :
		(ana_i.full_scale[0] ? 1000 : 500);
endmodule

// ### bench/tb_top.sv
// Purpose: Self-checking bench for the current DAC update scheduler
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Reset values and table of register writes first, then trigger modes
`timescale 1ns/1ps
module tb_top
	import cds_pkg::*;
;
	logic        core_clk_i = 0;
	logic        sys_rst_i  = 1;
	cds_wr_t     wr         = '0;
	logic [3:0]  tov        = '0;
	logic        cnv        = 0;
	logic [2:0]  gp         = 3'h7;
	logic        port0_skip_reg = 1'b0;
	logic [7:0]  ctrl, dh, dl, a;
	cds_ana_t    ana;
	logic [2:0]  pin;
	logic        upd, pad;
	logic [9:0]  old;
	int          fs;
	int          failures = 0;
	int          checks   = 0;
	logic [27:0] rows [5] = '{{2'h0, 8'hff, 8'hf3, 10'h000},
		{2'h0, 8'h72, 8'h72, 10'h000}, {2'h2, 8'hff, 8'hc0, 10'h000},
		{2'h1, 8'ha5, 8'ha5, 10'h297}, {2'h2, 8'h40, 8'h40, 10'h297}};

	always #2 core_clk_i = ~core_clk_i;

	cds_top dut_u (.core_clk_i, .sys_rst_i, .wr_i(wr), .timer_ovf_i(tov),
		.convert_start_pin_i(cnv), .gpio_out_i(gp[2]), .gpio_oe_i(gp[1]),
		.gpio_pullup_i(gp[0]), .dac_control_reg_o(ctrl),
		.dac_data_high_o(dh), .dac_data_low_o(dl), .ana_o(ana),
		.pin_out_o(pin[2]), .pin_oe_o(pin[1]), .pin_pullup_o(pin[0]),
		.update_o(upd));
	cds_ana_model mdl_u (.ana_i(ana), .pin_out_i(pin[2]),
		.pin_oe_i(pin[1]), .pin_pullup_i(pin[0]),
		.skip_i(port0_skip_reg), .pin_o(pad),
		.fs_ua_o(fs));

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	task automatic wr_reg(input logic [1:0] k, input logic [7:0] d);
		wr = {k == 2'h0, k == 2'h1, k == 2'h2, d};
		tick(1);
		wr = '0;
		tick(1);
	endtask
	task automatic pulse(input logic [3:0] m);
		tov = m;
		tick(1);
		tov = '0;
		tick(1);
	endtask
	task automatic end_of_test;
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		tick(2);
		sys_rst_i = 0;
		port0_skip_reg = 1'b1;
		chk(ctrl, CDS_CTRL_RST);
		chk({dh, dl, ana.code}, '0);
		chk(fs, 2000);
		chk({pin, pad, ana.bias_on}, 5'h1e);
		$display("reset test done");
		foreach (rows[i]) begin
			wr_reg(rows[i][27:26], rows[i][25:18]);
			a = rows[i][27:26] == 0 ? ctrl : (rows[i][27:26] == 1 ? dh : dl);
			chk({a, ana.code}, rows[i][17:0]);
		end
		$display("table test done");
		for (int f = 0; f < 4; f++) begin
			wr_reg(2'h0, {6'h1c, f[1:0]});
			chk(fs, f == 3 ? 2000 : 500 << f);
		end
		wr_reg(2'h0, 8'hf2);
		chk({pin, pad, ana.bias_on, ana.pin_analog}, 6'h03);
		wr_reg(2'h0, 8'h72);
		chk({pin, pad, ana.bias_on}, 5'h1e);
		$display("enable test done");
		for (int t = 0; t < 4; t++) begin
			wr_reg(2'h0, {1'b0, t[2:0], 4'h2});
			old = ana.code;
			wr_reg(2'h2, 8'h40);
			wr_reg(2'h1, t[7:0] + 8'h1);
			pulse(4'hf ^ (4'h1 << t));
			chk(ana.code, old);
			pulse(4'h1 << t);
			chk(ana.code, {t[7:0] + 8'h1, 2'b01});
		end
		$display("timer test done");
		for (int m = 4; m < 7; m++) begin
			wr_reg(2'h0, {1'b0, m[2:0], 4'h2});
			old = ana.code;
			a = 8'h11 * m[7:0];
			wr_reg(2'h1, a);
			cnv = 1;
			tick(8);
			chk(ana.code, m == 5 ? old : {a, 2'b01});
			wr_reg(2'h1, ~a);
			cnv = 0;
			tick(8);
			chk(ana.code, m == 4 ? {a, 2'b01} : {~a, 2'b01});
		end
		$display("edge test done");
		wr_reg(2'h0, CDS_CTRL_RST);
		wr_reg(2'h2, 8'hc0);
		wr = {3'b010, 8'h80};
		tick(1);
		wr = '0;
		chk({upd, ana.code}, {1'b1, 10'h203});
		tick(1);
		chk({upd, ana.code}, {1'b0, 10'h203});
		$display("update test done");
		sys_rst_i = 1;
		tick(2);
		sys_rst_i = 0;
		chk({ctrl, dl, upd, ana.code}, {CDS_CTRL_RST, 8'h00, 11'h000});
		wr_reg(2'h1, 8'h12);
		chk(ana.code, 10'h048);
		$display("second reset test done");
		end_of_test();
	end
endmodule
